// ==== src/rtcerr_pkg.sv ====
// package: constants, enums and structs of the tag command error handler
`default_nettype none
package rtcerr_pkg;
    // command codes of the received frame
    localparam logic [7:0] CMD_READ    = 8'h30;
    localparam logic [7:0] CMD_WRITE   = 8'hA2;
    localparam logic [7:0] CMD_SECSEL  = 8'hC2;
    // payload lengths in bytes, command byte included, crc excluded
    localparam logic [4:0] LEN_READ    = 5'h02;
    localparam logic [4:0] LEN_WRITE   = 5'h06;
    localparam logic [4:0] LEN_SECSEL  = 5'h02;
    // buffer window blocks
    localparam logic [7:0] BUF_FIRST   = 8'hFC;
    localparam logic [7:0] BUF_LAST    = 8'hFF;
    // reply codes on the four-bit nak channel
    localparam logic [3:0] NAK0_CODE   = 4'h0;
    localparam logic [3:0] NAK1_CODE   = 4'h1;
    localparam logic [3:0] NAK4_CODE   = 4'h4;
    localparam logic [3:0] NAK5_CODE   = 4'h5;
    localparam logic [3:0] ACK_CODE    = 4'hA;
    // bytes in one read answer
    localparam int         READ_BYTES  = 16;
    localparam logic [1:0] RST_TAG     = 2'h0;

    typedef enum logic [3:0] {
        RPL_NONE = 4'b0001,
        RPL_DATA = 4'b0010,
        RPL_ACK  = 4'b0100,
        RPL_NAK  = 4'b1000
    } rtcerr_reply_e;

    // frame summary delivered by the receiver
    typedef struct packed {
        logic       bitErr;
        logic       incomplete;
        logic       parityErr;
        logic       crcErr;
        logic       crcPresent;
        logic [4:0] len;
        logic [7:0] cmd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } rtcerr_frame_s;

    // memory attributes of the addressed range; exists and prot per byte of the answer, locked and collide for the whole range
    typedef struct packed {
        logic [15:0] exists;
        logic [15:0] prot;
        logic        locked;
        logic        collide;
    } rtcerr_mem_s;
endpackage
`default_nettype wire

// ==== src/rtcerr_masker.sv ====
// module: zero-fill of missing and protected bytes of a read answer
`default_nettype none
module rtcerr_masker
    import rtcerr_pkg::*;
(
    // raw data and per-byte attributes
    input  wire logic [127:0] rawData,
    input  wire logic [15:0]  exists,
    input  wire logic [15:0]  prot,
    // masked answer
    output logic      [127:0] outData
);
    // a byte is sent only if it exists and is unprotected
    always_comb begin
        for (int i = 0; i < READ_BYTES; i++) begin
            outData[i*8 +: 8] = (exists[i] && !prot[i]) ? rawData[i*8 +: 8] : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ==== src/rtcerr_handler.sv ====
// module: reply and tag state selection for received reader frames
`default_nettype none
// Function
// - errors sleep; clean write acks, selected
// - parity/crc: silent, or nak1 if enabled
// - malformed read length: silent, sleep
// - malformed write length: silent, sleep
// - one byte without crc: silent, sleep
// - two-byte write with crc: silent
// - nonexistent range: nak0, sleep
// - partial range read pads zero bytes
// - protected read: nak4 or zero bytes
// - interleaved eeprom write succeeds, buffer discarded
// - status flag reads always answered
// - three buffer flags read together
// - rx start int1; rx/tx end int0
// - first block busy; last block ready
// - bad buffer sequences get nak0, sleep
module rtcerr_handler
    import rtcerr_pkg::*;
(
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    // configuration
    input  wire logic          nakOnCrcParity,
    input  wire logic          extendedMode,
    // received frame
    input  wire logic          frameValid,
    input  wire rtcerr_frame_s frame,
    // memory view of the addressed range
    input  wire rtcerr_mem_s   mem,
    input  wire logic [127:0]  memData,
    // host side buffer actions
    input  wire logic          hostTransmit,
    input  wire logic          hostClear,
    // reply to the reader
    output logic               replyValid,
    output rtcerr_reply_e      replyKind,
    output logic [3:0]         replyCode,
    output logic [127:0]       replyData,
    output logic               tagSelected,
    // eeprom write strobe
    output logic               eepromWrite,
    output logic [7:0]         eepromAddr,
    output logic [31:0]        eepromData,
    // buffer flags and event bits
    output logic               reader_side_busy_flag,
    output logic               reader_data_ready_flag,
    output logic               hostDataReady,
    output logic [7:0]         bufStatus1,
    output logic               intRxStart,
    output logic               intRxEnd,
    output logic               intTxEnd,
    output logic [7:0]         intReg0,
    output logic [7:0]         intReg1
);
    rtcerr_reply_e kind;
    logic [3:0]    code;
    logic          isRead, isWrite, isSec, inBuf, lenBad, crcBad;
    logic          bufStart, bufEnd, bufTxEnd, evRxs, evRxe, evTxe, doEe;
    logic [127:0]  masked;
    logic [127:0]  statusWord;

    function automatic logic inWindow(input logic [7:0] a);
        inWindow = (a >= BUF_FIRST);
    endfunction

    assign isRead  = frame.cmd == CMD_READ;
    assign isWrite = frame.cmd == CMD_WRITE;
    assign isSec   = frame.cmd == CMD_SECSEL;
    assign inBuf   = extendedMode && inWindow(frame.addr);
    assign crcBad  = frame.parityErr || frame.crcErr;
    // length check covers empty, single-byte, missing fields and too long frames
    assign lenBad  = !frame.crcPresent
        || (isRead && frame.len != LEN_READ)
        || (isWrite && frame.len != LEN_WRITE)
        || (isSec && frame.len != LEN_SECSEL);
    // status word: fifteen buffer bytes zero, flags in the last byte
    assign statusWord = {bufStatus1, 120'h0};

    rtcerr_masker u_mask (
        .rawData (memData),
        .exists  (mem.exists),
        .prot    (mem.prot),
        .outData (masked)
    );

    // classify with fixed priority, exactly one outcome
    always_comb begin
        kind = RPL_NONE; code = NAK0_CODE; doEe = 1'b0;
        bufStart = 1'b0; bufEnd = 1'b0; bufTxEnd = 1'b0;
        if (frame.bitErr || frame.incomplete) begin
            kind = RPL_NONE;
        end else if (crcBad) begin
            kind = nakOnCrcParity ? RPL_NAK : RPL_NONE;
            code = NAK1_CODE;
        end else if (lenBad || !(isRead || isWrite)) begin
            kind = RPL_NONE;
        end else if (inBuf) begin
            if (isRead && frame.addr != BUF_FIRST) begin
                kind = RPL_NAK;
            end else if (isRead) begin
                kind = RPL_DATA;
            end else if (frame.addr == BUF_LAST && hostDataReady) begin
                kind = RPL_ACK; bufTxEnd = 1'b1;
            end else if (hostDataReady || reader_data_ready_flag
                         || (!reader_side_busy_flag && frame.addr != BUF_FIRST)) begin
                kind = RPL_NAK;
            end else begin
                kind = RPL_ACK;
                bufStart = frame.addr == BUF_FIRST;
                bufEnd = frame.addr == BUF_LAST;
            end
        end else if (mem.exists == 16'h0000) begin
            kind = RPL_NAK; code = NAK0_CODE;
        end else if (mem.collide) begin
            kind = RPL_NAK; code = NAK5_CODE;
        end else if (isWrite && mem.locked) begin
            kind = RPL_NAK; code = NAK0_CODE;
        end else if (mem.prot == 16'hFFFF || (isWrite && mem.prot[0])) begin
            kind = RPL_NAK; code = NAK4_CODE;
        end else if (isWrite) begin
            kind = RPL_ACK; doEe = 1'b1;
        end else begin
            kind = RPL_DATA;
        end
    end

    assign evRxs = frameValid && bufStart;
    assign evRxe = frameValid && bufEnd;
    assign evTxe = frameValid && bufTxEnd;

    // reply registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            replyValid <= 1'b0; replyKind <= RPL_NONE;
            replyCode <= NAK0_CODE; replyData <= 128'h0;
        end else begin
            replyValid <= frameValid;
            if (frameValid) begin
                replyKind <= kind;
                replyCode <= (kind == RPL_ACK) ? ACK_CODE : code;
                replyData <= (kind != RPL_DATA) ? 128'h0 : (inBuf ? statusWord : masked);
            end
        end
    end

    // tag state: only a successful write or read keeps selected
    always_ff @(posedge clock) begin
        if (!rst_n) tagSelected <= RST_TAG[0];
        else if (frameValid) tagSelected <= (kind == RPL_ACK) || (kind == RPL_DATA);
    end

    // eeprom write strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            eepromWrite <= 1'b0; eepromAddr <= 8'h00; eepromData <= 32'h0;
        end else begin
            eepromWrite <= frameValid && doEe;
            if (frameValid && doEe) begin
                eepromAddr <= frame.addr;
                eepromData <= frame.wdata;
            end
        end
    end

    // buffer flags; eeprom write discards a transfer, set wins over clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reader_side_busy_flag <= 1'b0; reader_data_ready_flag <= 1'b0;
            hostDataReady <= 1'b0;
        end else begin
            if (evRxs) reader_side_busy_flag <= 1'b1;
            else if (evRxe || (frameValid && doEe)) reader_side_busy_flag <= 1'b0;
            if (evRxe) reader_data_ready_flag <= 1'b1;
            else if (hostClear) reader_data_ready_flag <= 1'b0;
            if (hostTransmit) hostDataReady <= 1'b1;
            else if (evTxe || hostClear) hostDataReady <= 1'b0;
        end
    end
    assign bufStatus1 = {5'h00, hostDataReady, reader_data_ready_flag,
                         reader_side_busy_flag};

    // event pulses and interrupt register images
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            intRxStart <= 1'b0; intRxEnd <= 1'b0; intTxEnd <= 1'b0;
        end else begin
            intRxStart <= evRxs;
            intRxEnd <= evRxe;
            intTxEnd <= evTxe;
        end
    end
    assign intReg1 = {7'h00, intRxStart};
    assign intReg0 = {6'h00, intTxEnd, intRxEnd};

    // assertions
    property p_err_sleep;
        @(posedge clock) disable iff (!rst_n)
        replyValid && (replyKind == RPL_NAK || replyKind == RPL_NONE) |-> !tagSelected;
    endproperty
    a_err_sleep: assert property (p_err_sleep) else $error("error left tag selected");
    property p_crc;
        @(posedge clock) disable iff (!rst_n)
        frameValid && !frame.bitErr && !frame.incomplete && crcBad |=>
            replyKind == ($past(nakOnCrcParity) ? RPL_NAK : RPL_NONE);
    endproperty
    a_crc: assert property (p_crc) else $error("wrong crc reply");
    property p_len;
        @(posedge clock) disable iff (!rst_n)
        frameValid && !frame.bitErr && !frame.incomplete && !crcBad && lenBad
            |=> replyKind == RPL_NONE && !tagSelected;
    endproperty
    a_len: assert property (p_len) else $error("malformed frame answered");
    property p_nak5;
        @(posedge clock) disable iff (!rst_n)
        replyValid && replyCode == NAK5_CODE |-> !eepromWrite;
    endproperty
    a_nak5: assert property (p_nak5) else $error("collision wrote eeprom");
    property p_ack;
        @(posedge clock) disable iff (!rst_n)
        eepromWrite |-> replyKind == RPL_ACK && replyCode == ACK_CODE && tagSelected;
    endproperty
    a_ack: assert property (p_ack) else $error("write not acked");
    property p_rxs;
        @(posedge clock) disable iff (!rst_n)
        evRxs |=> reader_side_busy_flag && intReg1[0] ##1 !intRxStart;
    endproperty
    a_rxs: assert property (p_rxs) else $error("rx start missing");
    property p_rxe;
        @(posedge clock) disable iff (!rst_n)
        evRxe |=> reader_data_ready_flag && intReg0[0] && bufStatus1[1];
    endproperty
    a_rxe: assert property (p_rxe) else $error("rx end missing");
    property p_ready_block;
        @(posedge clock) disable iff (!rst_n)
        frameValid && kind == RPL_ACK && inBuf && isWrite |-> !reader_data_ready_flag;
    endproperty
    a_ready_block: assert property (p_ready_block) else $error("write accepted when ready");
    property p_discard;
        @(posedge clock) disable iff (!rst_n)
        frameValid && doEe |=> !reader_side_busy_flag;
    endproperty
    a_discard: assert property (p_discard) else $error("buffer not discarded");
    c_ack:  cover property (@(posedge clock) disable iff (!rst_n) eepromWrite);
    c_nak1: cover property (@(posedge clock) disable iff (!rst_n) replyValid && replyCode == NAK1_CODE);
    c_rxe:  cover property (@(posedge clock) disable iff (!rst_n) intRxEnd);
endmodule
`default_nettype wire

// ==== bench/rtcerr_reader.sv ====
// reader model: hands one frame summary per request to the tag
`default_nettype none
module rtcerr_reader
    import rtcerr_pkg::*;
(
    // clock
    input  wire logic     clock,
    // frame toward the tag
    output logic          frameValid,
    output rtcerr_frame_s frame,
    output rtcerr_mem_s   mem,
    output logic [127:0]  memData
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle at time zero
    initial begin
        frameValid = 1'b0;
        frame = '0;
        mem = '0;
        memData = '0;
    end
    // frame just after an edge; released fields show inverted stale values
    task automatic send(input rtcerr_frame_s f, input rtcerr_mem_s m, input logic [127:0] d,
                        input int gap);
        @(posedge clock);
        #2;
        frameValid = 1'b1;
        frame = f;
        mem = m;
        memData = d;
        repeat (gap) begin
            @(posedge clock);
            #2;
            frameValid = 1'b0;
            frame = ~frame;
            mem = ~mem;
            memData = ~memData;
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/rtcerr_handler_tb.sv ====
// bench: reader frames in, queued replies checked at the falling edge
`default_nettype none
module rtcerr_handler_tb
    import rtcerr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic          clock, rst_n, nakOnCrcParity, extendedMode, hostTransmit, hostClear;
    logic          frameValid, replyValid, tagSelected, eepromWrite;
    rtcerr_frame_s frame, f;
    rtcerr_mem_s   mem, mOk;
    rtcerr_reply_e replyKind;
    logic [3:0]    replyCode;
    logic [7:0]    bufStatus1, intReg0, intReg1;
    logic [2:0]    eFlag;
    logic [127:0]  memData, replyData, raw;
    logic [161:0]  obs;
    logic [161:0]  expQ[$];
    logic [39:0]   eeQ[$];
    logic [7:0]    eeAddr;
    logic [31:0]   eeData;
    int            fails, nTests, seed;
    logic [7:0]    cmds[3] = '{CMD_READ, CMD_WRITE, CMD_SECSEL};
    logic [4:0]    lens[3] = '{LEN_READ, LEN_WRITE, LEN_SECSEL};
    logic [7:0]    bad[10] = '{8'h20, 8'h21, 8'h01, 8'h23, 8'h41, 8'h61, 8'h62, 8'h64,
                               8'h67, 8'h81};
    rtcerr_reader rdr (.clock(clock), .frameValid(frameValid), .frame(frame), .mem(mem),
        .memData(memData));
    rtcerr_handler dut (.clock(clock), .rst_n(rst_n), .nakOnCrcParity(nakOnCrcParity),
        .extendedMode(extendedMode), .frameValid(frameValid), .frame(frame), .mem(mem),
        .memData(memData), .hostTransmit(hostTransmit), .hostClear(hostClear),
        .replyValid(replyValid), .replyKind(replyKind), .replyCode(replyCode),
        .replyData(replyData), .tagSelected(tagSelected), .eepromWrite(eepromWrite),
        .eepromAddr(eeAddr), .eepromData(eeData),
        .reader_side_busy_flag(), .reader_data_ready_flag(),
        .hostDataReady(), .bufStatus1(bufStatus1), .intRxStart(), .intRxEnd(), .intTxEnd(),
        .intReg0(intReg0), .intReg1(intReg1));
    // everything the reply cycle shows, in one vector
    assign obs = {replyKind, replyCode, tagSelected, eepromWrite, bufStatus1, intReg0,
                  intReg1, replyData};
    // clock and watchdog
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        #(25 * 3000);
        fails++;
        summarize();
    end
    task automatic summarize();
        if (fails == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic compare(input logic [161:0] got, input logic [161:0] want);
        nTests++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    // eeprom strobe carries the address and data that the reader sent
    task automatic compareEe(input logic [39:0] got, input logic [39:0] want);
        nTests++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    // reply monitor pops the oldest note
    always @(negedge clock) begin
        if (replyValid === 1'b1)
            compare(obs, (expQ.size() > 0) ? expQ.pop_front() : 162'h0);
    end
    // eeprom monitor pops the oldest write note
    always @(negedge clock) begin
        if (eepromWrite === 1'b1)
            compareEe({eeAddr, eeData}, (eeQ.size() > 0) ? eeQ.pop_front() : 40'h0);
    end
    function automatic rtcerr_frame_s mk(input logic [7:0] c, input logic [4:0] n,
                                         input logic [7:0] a);
        mk = '0;
        mk.cmd = c;
        mk.len = n;
        mk.addr = a;
        mk.crcPresent = 1'b1;
        mk.wdata = $random(seed);
    endfunction
    function automatic rtcerr_mem_s mm(input logic [15:0] e, input logic [15:0] p,
                                       input logic l, input logic c);
        mm = {e, p, l, c};
    endfunction
    // expected read answer: kept bytes of raw, zero elsewhere
    function automatic logic [127:0] keep(input logic [15:0] k);
        for (int i = 0; i < 16; i++)
            keep[i*8 +: 8] = k[i] ? raw[i*8 +: 8] : 8'h00;
    endfunction
    // note the expected reply, then send; ev is {txEnd, rxEnd, rxStart}
    task automatic go(input rtcerr_frame_s fr, input rtcerr_mem_s m, input rtcerr_reply_e k,
                      input logic [3:0] c, input logic s, input logic w, input logic [2:0] ev,
                      input logic [127:0] d, input int gap);
        expQ.push_back({k, c, s, w, 5'h0, eFlag, 6'h0, ev[2:1], 7'h0, ev[0], d});
        if (w)
            eeQ.push_back({fr.addr, fr.wdata});
        rdr.send(fr, m, raw, gap);
    endtask
    task automatic wok();
        go(mk(CMD_WRITE, LEN_WRITE, 8'h08), mOk, RPL_ACK, ACK_CODE, 1, 1, 0, 0, 0);
    endtask
    // selected first, then a memory case
    task automatic mc(input logic w, input rtcerr_mem_s m, input rtcerr_reply_e k,
                      input logic [3:0] c, input logic [15:0] kp);
        wok();
        raw = {$random(seed), $random(seed), $random(seed), $random(seed)};
        go(mk(w ? CMD_WRITE : CMD_READ, w ? LEN_WRITE : LEN_READ, 8'h10), m, k, c,
           k != RPL_NAK, k == RPL_ACK, 0, (k == RPL_DATA) ? keep(kp) : 128'h0, 1);
    endtask
    task automatic bw(input logic [7:0] a, input rtcerr_reply_e k, input logic [2:0] ev);
        f = mk(CMD_WRITE, LEN_WRITE, a);
        f.wdata = 32'h0;
        go(f, mOk, k, (k == RPL_ACK) ? ACK_CODE : NAK0_CODE, k == RPL_ACK, 0, ev, 0, 1);
    endtask
    task automatic stat(input logic s);
        go(mk(CMD_READ, LEN_READ, BUF_FIRST), mOk, RPL_DATA, 0, s, 0, 0, {5'h0, eFlag, 120'h0}, 1);
    endtask
    task automatic host(input logic t);
        @(posedge clock);
        #2;
        hostTransmit = t;
        hostClear = !t;
        @(posedge clock);
        #2;
        hostTransmit = 1'b0;
        hostClear = 1'b0;
    endtask
    // main sequence
    initial begin
        seed = 32'h417db272;
        {rst_n, nakOnCrcParity, extendedMode, hostTransmit, hostClear, eFlag} = '0;
        mOk = mm(16'hFFFF, 16'h0, 1'b0, 1'b0);
        raw = {$random(seed), $random(seed), $random(seed), $random(seed)};
        repeat (5) @(posedge clock);
        #2;
        rst_n = 1'b1;
        compare(obs, {RPL_NONE, 158'h0});
        for (int i = 0; i < 12; i++) begin
            nakOnCrcParity = (i >= 6);
            f = mk(cmds[i % 3], lens[i % 3], 8'h04);
            f.parityErr = ((i / 3) % 2 == 0);
            f.crcErr = ((i / 3) % 2 == 1);
            wok();
            go(f, mOk, nakOnCrcParity ? RPL_NAK : RPL_NONE, NAK1_CODE, 0, 0, 0, 0, 1);
        end
        f = mk(CMD_READ, LEN_READ, 8'h04);
        f.bitErr = 1'b1;
        f.parityErr = 1'b1;
        wok();
        go(f, mOk, RPL_NONE, 0, 0, 0, 0, 0, 1);
        for (int i = 0; i < 10; i++) begin
            f = mk(cmds[bad[i][7:6]], bad[i][4:0], 8'h04);
            f.crcPresent = bad[i][5];
            wok();
            go(f, mOk, RPL_NONE, 0, 0, 0, 0, 0, 1);
        end
        mc(0, mm(16'h0, 16'h0, 0, 0), RPL_NAK, NAK0_CODE, 0);
        mc(1, mm(16'h0, 16'h0, 0, 1), RPL_NAK, NAK0_CODE, 0);
        mc(0, mm(16'h00FF, 16'h0, 0, 0), RPL_DATA, 0, 16'h00FF);
        mc(0, mm(16'hFFFF, 16'hFFFF, 0, 0), RPL_NAK, NAK4_CODE, 0);
        mc(0, mm(16'hFFFF, 16'hF0F0, 0, 0), RPL_DATA, 0, 16'h0F0F);
        mc(1, mm(16'hFFFF, 16'h0001, 0, 0), RPL_NAK, NAK4_CODE, 0);
        mc(0, mm(16'hFFFF, 16'h0, 0, 1), RPL_NAK, NAK5_CODE, 0);
        mc(1, mm(16'hFFFF, 16'h0, 1, 1), RPL_NAK, NAK5_CODE, 0);
        mc(1, mm(16'hFFFF, 16'h0, 1, 0), RPL_NAK, NAK0_CODE, 0);
        mc(0, mm(16'hFFFF, 16'h0, 1, 0), RPL_DATA, 0, 16'hFFFF);
        extendedMode = 1'b1;
        eFlag = 3'b001;
        bw(BUF_FIRST, RPL_ACK, 3'b001);
        bw(8'hFD, RPL_ACK, 3'b000);
        eFlag = 3'b010;
        bw(BUF_LAST, RPL_ACK, 3'b010);
        stat(1);
        bw(BUF_FIRST, RPL_NAK, 3'b000);
        host(0);
        eFlag = 3'b000;
        go(mk(CMD_READ, LEN_READ, 8'hFD), mOk, RPL_NAK, NAK0_CODE, 0, 0, 0, 0, 1);
        bw(8'hFE, RPL_NAK, 3'b000);
        eFlag = 3'b001;
        bw(BUF_FIRST, RPL_ACK, 3'b001);
        stat(1);
        eFlag = 3'b000;
        go(mk(CMD_WRITE, LEN_WRITE, 8'h08), mOk, RPL_ACK, ACK_CODE, 1, 1, 0, 0, 1);
        host(1);
        eFlag = 3'b100;
        stat(1);
        eFlag = 3'b000;
        bw(BUF_LAST, RPL_ACK, 3'b100);
        // reset in mid-transfer drops every flag and the selection
        eFlag = 3'b001;
        bw(BUF_FIRST, RPL_ACK, 3'b001);
        @(posedge clock);
        #2;
        rst_n = 1'b0;
        @(posedge clock);
        #2;
        rst_n = 1'b1;
        compare(obs, {RPL_NONE, 158'h0});
        // polite reader: status shows idle, then the eeprom write
        eFlag = 3'b000;
        stat(1);
        go(mk(CMD_WRITE, LEN_WRITE, 8'h08), mOk, RPL_ACK, ACK_CODE, 1, 1, 0, 0, 1);
        repeat (4) @(posedge clock);
        if (expQ.size() != 0)
            compare(162'h0, expQ.pop_front());
        if (eeQ.size() != 0)
            compareEe(40'h0, eeQ.pop_front());
        summarize();
    end
endmodule
`default_nettype wire
